// >>> logic/slbc_top.sv
`timescale 1ns/100ps
// Behaviour
// - sample every strap pin on the first edge after internal reset release, hold bits until recaptured after the next reset
// - held strap bits readable from the strap status register
// - after reset release strap pins as normal pins, latched bits unchanged
// - during reset pull boot-select up and other two strap pins down
// - flash-supply strap 0 selects 3.3 V, 1 selects 1.8 V
// - supply-force fuse set: use supply-tie fuse instead of strap bit
// - boot-select 1 flash boot, 0 with print 0 download; 0/1 invalid
// - print fuse 0 always, 1 strap low, 2 strap high, 3 never
// - boot messages go to serial tx, or converter pin when fuse set
module slbc_top
    import slbc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // strap pins and fuses
    input wire slbc_strap_t strap_in,
    input wire slbc_fuse_t fuse_in,
    // pulls on strap pins
    output logic [2:0] pull_up_en,
    output logic [2:0] pull_dn_en,
    output logic strap_release,
    // decoded boot configuration
    output logic flash_supply_sel,
    output slbc_boot_t boot_mode,
    output logic print_en,
    output logic print_to_tx,
    output logic print_to_conv,
    // register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata
);
    logic rst_s1_r;
    logic rst_s2_r;
    logic held_valid_r;
    slbc_strap_t strap_r;

    // async assert, synchronous release
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // pulls stay on until the latch holds, so the capture edge still sees them
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            pull_up_en <= PULL_UP_MASK;
            pull_dn_en <= PULL_DN_MASK;
            strap_release <= 1'b0;
        end else begin
            pull_up_en <= held_valid_r ? 3'h0 : PULL_UP_MASK;
            pull_dn_en <= held_valid_r ? 3'h0 : PULL_DN_MASK;
            strap_release <= held_valid_r;
        end
    end

    // capture once on the first edge after internal release; pins are
    // sampled in a clocked process since async reset must load constants
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            held_valid_r <= 1'b0;
        end else begin
            held_valid_r <= 1'b1;
        end
    end

    // strap latch is not reset so the bits survive until recaptured
    always_ff @(posedge mclk) begin
        if (rst_s2_r && !held_valid_r) begin
            strap_r <= strap_in;
        end
    end

    // decode, registered so outputs come from flops
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            flash_supply_sel <= SUPPLY_3V3;
            boot_mode <= SLBC_BOOT_FLASH;
            print_en <= 1'b0;
            print_to_tx <= 1'b0;
            print_to_conv <= 1'b0;
        end else if (held_valid_r) begin
            flash_supply_sel <= fuse_in.supply_force ? fuse_in.supply_tie
                                : strap_r.supply_strap;
            if (strap_r.boot_select) begin
                boot_mode <= SLBC_BOOT_FLASH;
            end else if (!strap_r.print_strap) begin
                boot_mode <= SLBC_BOOT_DOWNLOAD;
            end else begin
                boot_mode <= SLBC_BOOT_INVALID;
            end
            unique case (fuse_in.print_ctrl)
                PRN_ALWAYS: print_en <= 1'b1;
                PRN_IF_LOW: print_en <= !strap_r.print_strap;
                PRN_IF_HIGH: print_en <= strap_r.print_strap;
                PRN_NEVER: print_en <= 1'b0;
            endcase
            print_to_tx <= !fuse_in.print_route;
            print_to_conv <= fuse_in.print_route;
        end
    end

    // read port: strap status and decoded boot word; writes ignored
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            rdata <= RD_ZERO;
        end else if (rd_stb) begin
            unique case (addr)
                ADDR_STRAP: rdata <= {29'h0, strap_r};
                ADDR_BOOT: rdata <= {26'h0, print_to_conv, print_to_tx, print_en,
                                     boot_mode, flash_supply_sel};
                default: rdata <= RD_ZERO;
            endcase
        end else begin
            rdata <= RD_ZERO;
        end
    end

    // decoded outputs are registered, so their checks look one cycle back
    strap_hold_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        held_valid_r && $past(held_valid_r)
        |-> $stable(strap_r))
        else $error("strap bits changed after capture");

    capture_edge_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $rose(held_valid_r)
        |-> strap_r == $past(strap_in))
        else $error("strap capture mismatch");

    capture_pulled_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $rose(held_valid_r)
        |-> $past(pull_up_en) == PULL_UP_MASK && $past(pull_dn_en) == PULL_DN_MASK)
        else $error("strap pins sampled without pulls");

    pull_release_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        strap_release
        |-> pull_up_en == 3'h0 && pull_dn_en == 3'h0)
        else $error("pulls still on after release");

    release_after_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $rose(strap_release)
        |-> $past(held_valid_r))
        else $error("pins released before capture");

    pull_reset_a: assert property (@(posedge mclk)
        !rst_s2_r ##1 !rst_s2_r
        |-> pull_up_en == PULL_UP_MASK && pull_dn_en == PULL_DN_MASK)
        else $error("strap pulls missing in reset");

    supply_sel_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $past(held_valid_r) && !$past(fuse_in.supply_force)
        |-> flash_supply_sel == $past(strap_r.supply_strap))
        else $error("supply select not from strap");

    supply_force_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $past(held_valid_r) && $past(fuse_in.supply_force)
        |-> flash_supply_sel == $past(fuse_in.supply_tie))
        else $error("supply fuse override ignored");

    boot_dec_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $past(held_valid_r) && $past(strap_r.boot_select)
        |-> boot_mode == SLBC_BOOT_FLASH)
        else $error("boot select high not flash boot");

    boot_download_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $past(held_valid_r) && !$past(strap_r.boot_select) && !$past(strap_r.print_strap)
        |-> boot_mode == SLBC_BOOT_DOWNLOAD)
        else $error("download straps not download boot");

    print_always_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $past(held_valid_r) && $past(fuse_in.print_ctrl) == PRN_ALWAYS
        |-> print_en)
        else $error("print disabled with always fuse");

    print_low_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $past(held_valid_r) && $past(fuse_in.print_ctrl) == PRN_IF_LOW
        |-> print_en == !$past(strap_r.print_strap))
        else $error("print gate wrong for strap low fuse");

    print_high_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $past(held_valid_r) && $past(fuse_in.print_ctrl) == PRN_IF_HIGH
        |-> print_en == $past(strap_r.print_strap))
        else $error("print gate wrong for strap high fuse");

    print_never_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $past(held_valid_r) && $past(fuse_in.print_ctrl) == PRN_NEVER
        |-> !print_en)
        else $error("print enabled with never fuse");

    print_route_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        $past(held_valid_r)
        |-> print_to_conv == $past(fuse_in.print_route) && print_to_tx != print_to_conv)
        else $error("print route not from fuse");

    strap_read_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        rd_stb && addr == ADDR_STRAP
        |=> rdata[2:0] == $past(strap_r))
        else $error("strap status read wrong");

    read_idle_a: assert property (@(posedge mclk) disable iff (!rst_s2_r)
        !rd_stb
        |=> rdata == RD_ZERO)
        else $error("read data not cleared");

    download_c: cover property (@(posedge mclk) boot_mode == SLBC_BOOT_DOWNLOAD);
    forced_c: cover property (@(posedge mclk) $past(fuse_in.supply_force) && flash_supply_sel);
    print_c: cover property (@(posedge mclk) print_en && print_to_conv);
    reboot_c: cover property (@(posedge mclk) $fell(strap_release));
    strap_read_c: cover property (@(posedge mclk) rd_stb && addr == ADDR_STRAP);
endmodule

// >>> include/slbc_pkg.sv
package slbc_pkg;
    // strap bit positions inside the held strap word
    localparam int STRAP_W = 3;
    localparam int BIT_BOOT = 0;
    localparam int BIT_SUPPLY = 1;
    localparam int BIT_PRINT = 2;
    // pull defaults while reset is asserted: boot-select up, others down
    localparam logic [2:0] PULL_UP_MASK = 3'h1;
    localparam logic [2:0] PULL_DN_MASK = 3'h6;
    // register map over the plain port
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_STRAP = 4'h0;
    localparam logic [3:0] ADDR_BOOT = 4'h4;
    localparam logic [31:0] RD_ZERO = 32'h0;
    // print-control fuse codes
    localparam logic [1:0] PRN_ALWAYS = 2'h0;
    localparam logic [1:0] PRN_IF_LOW = 2'h1;
    localparam logic [1:0] PRN_IF_HIGH = 2'h2;
    localparam logic [1:0] PRN_NEVER = 2'h3;
    // flash supply select value: 0 = 3.3 V, 1 = 1.8 V
    localparam logic SUPPLY_3V3 = 1'b0;
    localparam logic SUPPLY_1V8 = 1'b1;

    typedef enum logic [1:0] {
        SLBC_BOOT_FLASH,
        SLBC_BOOT_DOWNLOAD,
        SLBC_BOOT_INVALID
    } slbc_boot_t;

    typedef struct packed {
        logic supply_force;
        logic supply_tie;
        logic [1:0] print_ctrl;
        logic print_route;
    } slbc_fuse_t;

    typedef struct packed {
        logic print_strap;
        logic supply_strap;
        logic boot_select;
    } slbc_strap_t;
endpackage

// >>> test/slbc_strap_host.sv
`timescale 1ns/100ps
module slbc_strap_host
    import slbc_pkg::*;
(
    input wire logic mclk,
    input wire logic [2:0] pull_up_en,
    input wire logic [2:0] pull_dn_en,
    input wire logic [2:0] host_en,
    input wire logic [2:0] host_val,
    output slbc_strap_t strap_in
);
    logic [2:0] lvl_r;
    // floating pin with no pull drifts: inverse of last level, never a stale copy
    always_ff @(posedge mclk) lvl_r <= strap_in;
    // host drive beats the weak pulls; host never drives boot 0 with print 1
    assign strap_in = (host_en & host_val) | (~host_en & pull_up_en)
        | (~host_en & ~pull_up_en & ~pull_dn_en & ~lvl_r);
endmodule

// >>> test/slbc_top_tb.sv
`timescale 1ns/100ps
module slbc_top_tb;
    import slbc_pkg::*;
    logic mclk = 0, rstn = 0, wr_stb = 0, rd_stb = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [2:0] pull_up_en, pull_dn_en, host_en = 3'h0, host_val = 3'h0;
    slbc_fuse_t fuse_in = '0;
    slbc_strap_t strap_in;
    slbc_boot_t boot_mode;
    logic strap_release, flash_supply_sel, print_en, print_to_tx, print_to_conv;
    int miscompares = 0, n_compared = 0;
    // chip enable low for at least 50 us at 8 ns per cycle
    localparam int CE_LOW_CYC = 6250;
    initial forever #4 mclk = ~mclk;
    slbc_strap_host host (.mclk(mclk), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
        .host_en(host_en), .host_val(host_val), .strap_in(strap_in));
    slbc_top dut (.mclk(mclk), .rstn(rstn), .strap_in(strap_in), .fuse_in(fuse_in),
        .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .strap_release(strap_release),
        .flash_supply_sel(flash_supply_sel), .boot_mode(boot_mode), .print_en(print_en),
        .print_to_tx(print_to_tx), .print_to_conv(print_to_conv), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic [31:0] exp_word(logic [2:0] s, logic [4:0] f);
        logic sup, pen;
        slbc_boot_t md;
        sup = f[4] ? f[3] : s[BIT_SUPPLY];
        md = s[0] ? SLBC_BOOT_FLASH : (s[2] ? SLBC_BOOT_INVALID : SLBC_BOOT_DOWNLOAD);
        case (f[2:1])
            PRN_ALWAYS: pen = 1'b1;
            PRN_IF_LOW: pen = ~s[BIT_PRINT];
            PRN_IF_HIGH: pen = s[BIT_PRINT];
            default: pen = 1'b0;
        endcase
        return {26'h0, f[0], ~f[0], pen, md, sup};
    endfunction
    // one power cycle with the host pattern, then sweep the fuses
    task automatic boot_case(logic [2:0] en, logic [2:0] val, logic [2:0] exp_s);
        logic [31:0] d;
        logic [31:0] o;
        logic [4:0] f;
        @(posedge mclk);
        rstn <= 1'b0;
        host_en <= en;
        host_val <= val;
        repeat (CE_LOW_CYC) @(posedge mclk);
        chk("pull_up", {29'h0, PULL_UP_MASK}, {29'h0, pull_up_en});
        chk("pull_dn", {29'h0, PULL_DN_MASK}, {29'h0, pull_dn_en});
        chk("release_rst", 32'h0, {31'h0, strap_release});
        rstn <= 1'b1;
        repeat (5) @(posedge mclk);
        chk("release", 32'h1, {31'h0, strap_release});
        chk("pulls_off", 32'h0, {26'h0, pull_up_en, pull_dn_en});
        host_val <= ~val;
        host_en <= 3'h7;
        wr_stb <= 1'b1;
        wdata <= 32'hFFFFFFFF;
        @(posedge mclk);
        wr_stb <= 1'b0;
        rd(ADDR_STRAP, d);
        chk("strap_reg", {29'h0, exp_s}, d);
        rd(4'h8, d);
        chk("unmapped", RD_ZERO, d);
        for (int i = 0; i < 8; i++) begin
            f = {i[2], i[0], i[1:0], i[1]};
            fuse_in <= slbc_fuse_t'(f);
            repeat (3) @(posedge mclk);
            rd(ADDR_BOOT, d);
            chk("boot_word", exp_word(exp_s, f), d);
            o = {26'h0, print_to_conv, print_to_tx, print_en, boot_mode, flash_supply_sel};
            chk("boot_out", exp_word(exp_s, f), o);
        end
    endtask
    task automatic test_done;
        if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        boot_case(3'h0, 3'h0, 3'h1);
        boot_case(3'h7, 3'h2, 3'h2);
        boot_case(3'h7, 3'h5, 3'h5);
        boot_case(3'h6, 3'h4, 3'h5);
        test_done();
    end
    initial begin
        // four power cycles of about 6300 cycles each, with margin
        #300us;
        miscompares++;
        test_done();
    end
endmodule
